// [rtl/ghtc_pkg.sv]
// Package for the gyro heading tracker and configuration block
package ghtc_pkg;
  // Configuration word as held and read back over APB (26 bits)
  typedef struct packed {
    logic main_mode;
    logic [2:0] log_level;
    logic [2:0] baud;
    logic pwr_msg;
    logic [1:0] rot;
    logic [2:0] rate;
    logic [1:0] sentence;
    logic talker;
    logic checksum;
    logic in_range;
    logic [2:0] sync_gear;
    logic [1:0] ref_freq;
    logic [2:0] step_gear;
  } ghtc_cfg_type;

  // Front panel keys, one-cycle pulses
  typedef struct packed {
    logic set;
    logic exit;
    logic plus;
    logic minus;
  } ghtc_keys_type;

  typedef enum logic [2:0] {
    MS_NORMAL = 3'b000,
    MS_TOP = 3'b001,
    MS_ALIGN = 3'b010,
    MS_MAIN = 3'b011,
    MS_SUB = 3'b100,
    MS_EDIT = 3'b101
  } ghtc_menu_type;

  // Field encodings
  localparam logic MODE_SYNCHRO = 1'b0;
  localparam logic MODE_STEPPER = 1'b1;
  localparam logic [2:0] BAUD_4800 = 3'h2;
  localparam logic [2:0] BAUD_MAX = 3'h6;
  localparam logic [2:0] LOG_MAX = 3'h4;
  localparam logic [2:0] RATE_30HZ = 3'h5;
  localparam logic [2:0] RATE_20HZ = 3'h4;
  localparam logic [2:0] GEAR_360 = 3'h0;
  localparam logic [2:0] GEAR_90 = 3'h2;
  localparam logic [2:0] GEAR_36 = 3'h4;
  localparam logic [2:0] GEAR_1X = 3'h5;
  localparam logic [1:0] REF_50_60 = 2'h2;
  localparam logic [2:0] PRESET_OFF = 3'h0;
  localparam logic [2:0] PRESET_DEFAULT = 3'h1;
  localparam logic [2:0] PRESET_MAX = 3'h5;

  // Value after reset equals the default preset bundle
  localparam ghtc_cfg_type CFG_RESET = '{main_mode: 1'b1, log_level: 3'h2, baud: 3'h2,
    pwr_msg: 1'b1, rot: 2'h0, rate: 3'h0, sentence: 2'h0, talker: 1'b0, checksum: 1'b1,
    in_range: 1'b1, sync_gear: 3'h0, ref_freq: 2'h2, step_gear: 3'h1};

  // Heading unit is 1/360 degree
  localparam logic [16:0] HEAD_FULL = 17'h1FA40;
  localparam logic [16:0] SECTOR_SPAN = 17'h05460;
  localparam logic [16:0] ALIGN_STEP = 17'h00024;
  localparam logic [16:0] HEAD_RESET = 17'h00000;

  // APB byte offsets
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_PRESET = 8'h04;
  localparam logic [7:0] OFS_HEADING = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_PROD_ID = 8'h10;
  localparam logic [7:0] OFS_SERIAL = 8'h14;
  localparam logic [7:0] OFS_VERSION = 8'h18;
endpackage

// [rtl/ghtc_top.sv]
// Gyro heading tracker with configuration store, key menu and APB slave
// Behaviour
// - Stepper phases are on/off bits giving six 60 degree sectors.
// - Direction comes from order of phase changes; swapping two reverses it.
// - Cyclic rotation of phase wiring shifts decoded angle by 120 degrees.
// - Synchro polarity resolved against reference; swapped reference adds 180 degrees.
// - Geared formats track relative moves from a supplied heading; 1x is absolute.
// - Alignment shows heading, plus/minus adjust, set commits and returns to normal.
// - Set enters or commits, exit leaves, plus/minus step item or value.
// - Main mode selects synchro or stepper decoding.
// - Log level has five choices.
// - Baud rate has seven choices, 1200 to 57600.
// - Power-on identification message can be enabled or disabled.
// - Rate-of-turn output is off or on with HE, TI or II talker.
// - Heading update rate has eight choices, 1 to 50 per second.
// - Heading sentence is HDT, HDG, THS or XDR.
// - Heading talker is HE or II; checksum separately switchable.
// - Synchro gear has six ratios including 1x; input range 11 V or 90 V.
// - Synchro reference frequency has four choices.
// - Stepper gear has five ratios, no 1x.
// - Preset overwrites settings with a fixed bundle.
// - Off preset changes nothing; the latest change always wins.
// - Product data entries are read-only.
// - Update rates of 30 per second or more need baud above 4800.
// - Leaving set-up menus triggers a store to non-volatile memory.
module ghtc_top #(
  parameter logic [31:0] PROD_ID = 32'h0000_1234, // Arbitrary value
  parameter logic [31:0] SERIAL = 32'h0000_0001, // Arbitrary value
  parameter logic [31:0] VERSION = 32'h0000_0100 // Arbitrary value
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic phase_in_one_i,
  input wire logic phase_in_two_i,
  input wire logic phase_in_three_i,
  input wire logic ref_in_one_i,
  input wire logic ref_in_two_i,
  input wire ghtc_pkg::ghtc_keys_type keys_i,
  output ghtc_pkg::ghtc_cfg_type cfg_o,
  output logic [2:0] preset_o,
  output logic [16:0] heading_o,
  output ghtc_pkg::ghtc_menu_type menu_state_o,
  output logic [2:0] menu_main_o,
  output logic [3:0] menu_sub_o,
  output logic [3:0] edit_value_o,
  output logic [16:0] align_value_o,
  output logic nv_store_o
);

  // Pattern {one,two,three} to sector; bit 3 marks a legal pattern
  function automatic logic [3:0] sector_of(input logic [2:0] p);
    unique case (p)
      3'h4: sector_of = 4'h8;
      3'h6: sector_of = 4'h9;
      3'h2: sector_of = 4'hA;
      3'h3: sector_of = 4'hB;
      3'h1: sector_of = 4'hC;
      3'h5: sector_of = 4'hD;
      default: sector_of = 4'h0;
    endcase
  endfunction

  // Heading change per sector for each gear index
  function automatic logic [16:0] gear_step(input logic [2:0] g);
    unique case (g)
      3'h0: gear_step = 17'h0003C;
      3'h1: gear_step = 17'h00078;
      3'h2: gear_step = 17'h000F0;
      3'h3: gear_step = 17'h001E0;
      3'h4: gear_step = 17'h00258;
      default: gear_step = ghtc_pkg::SECTOR_SPAN;
    endcase
  endfunction

  function automatic logic [16:0] wrap_add(input logic [16:0] h, input logic [16:0] s);
    logic [17:0] sum;
    sum = {1'b0, h} + {1'b0, s};
    if (sum >= {1'b0, ghtc_pkg::HEAD_FULL})
      sum = sum - {1'b0, ghtc_pkg::HEAD_FULL};
    wrap_add = sum[16:0];
  endfunction

  function automatic logic [16:0] wrap_sub(input logic [16:0] h, input logic [16:0] s);
    if (h < s)
      wrap_sub = h + ghtc_pkg::HEAD_FULL - s;
    else
      wrap_sub = h - s;
  endfunction

  // Clamp fields to legal codes and enforce the rate versus baud limit
  function automatic ghtc_pkg::ghtc_cfg_type sanitize(input ghtc_pkg::ghtc_cfg_type c);
    sanitize = c;
    if (c.log_level > ghtc_pkg::LOG_MAX)
      sanitize.log_level = ghtc_pkg::LOG_MAX;
    if (c.baud > ghtc_pkg::BAUD_MAX)
      sanitize.baud = ghtc_pkg::BAUD_MAX;
    if (c.sync_gear > ghtc_pkg::GEAR_1X)
      sanitize.sync_gear = ghtc_pkg::GEAR_1X;
    if (c.step_gear > ghtc_pkg::GEAR_36)
      sanitize.step_gear = ghtc_pkg::GEAR_36;
    if (sanitize.baud <= ghtc_pkg::BAUD_4800 && c.rate >= ghtc_pkg::RATE_30HZ)
      sanitize.rate = ghtc_pkg::RATE_20HZ;
  endfunction

  // Preset bundles; settings marked not applicable keep their value
  function automatic ghtc_pkg::ghtc_cfg_type apply_preset(input ghtc_pkg::ghtc_cfg_type c,
      input logic [2:0] p);
    apply_preset = c;
    if (p == ghtc_pkg::PRESET_DEFAULT)
    begin
      apply_preset = ghtc_pkg::CFG_RESET;
      apply_preset.log_level = c.log_level;
      apply_preset.sync_gear = c.sync_gear;
      apply_preset.ref_freq = c.ref_freq;
    end
    else if (p != ghtc_pkg::PRESET_OFF && p <= ghtc_pkg::PRESET_MAX)
    begin
      apply_preset = ghtc_pkg::CFG_RESET;
      apply_preset.log_level = c.log_level;
      apply_preset.step_gear = c.step_gear;
      apply_preset.main_mode = ghtc_pkg::MODE_SYNCHRO;
      apply_preset.in_range = p[0];
      apply_preset.sync_gear = (p >= 3'h4) ? ghtc_pkg::GEAR_90 : ghtc_pkg::GEAR_360;
      apply_preset.ref_freq = ghtc_pkg::REF_50_60;
    end
  endfunction

  // Number of submenu entries of each main menu
  function automatic logic [3:0] sub_count(input logic [2:0] m);
    unique case (m)
      3'h1: sub_count = 4'hC;
      3'h2: sub_count = 4'h2;
      3'h3: sub_count = 4'h7;
      3'h4: sub_count = 4'h3;
      default: sub_count = 4'h1;
    endcase
  endfunction

  // Number of choices of each editable item
  function automatic logic [3:0] val_count(input logic [2:0] m, input logic [3:0] s);
    unique case ({m, s})
      7'h22: val_count = 4'h5;
      7'h31: val_count = 4'h7;
      7'h33, 7'h35, 7'h43: val_count = 4'h4;
      7'h34: val_count = 4'h8;
      7'h42: val_count = 4'h6;
      7'h51: val_count = 4'h5;
      7'h61: val_count = 4'h6;
      default: val_count = 4'h2;
    endcase
  endfunction

  function automatic logic [3:0] get_field(input ghtc_pkg::ghtc_cfg_type c,
      input logic [2:0] pre, input logic [2:0] m, input logic [3:0] s);
    unique case ({m, s})
      7'h21: get_field = {3'h0, c.main_mode};
      7'h22: get_field = {1'b0, c.log_level};
      7'h31: get_field = {1'b0, c.baud};
      7'h32: get_field = {3'h0, c.pwr_msg};
      7'h33: get_field = {2'h0, c.rot};
      7'h34: get_field = {1'b0, c.rate};
      7'h35: get_field = {2'h0, c.sentence};
      7'h36: get_field = {3'h0, c.talker};
      7'h37: get_field = {3'h0, c.checksum};
      7'h41: get_field = {3'h0, c.in_range};
      7'h42: get_field = {1'b0, c.sync_gear};
      7'h43: get_field = {2'h0, c.ref_freq};
      7'h51: get_field = {1'b0, c.step_gear};
      default: get_field = {1'b0, pre};
    endcase
  endfunction

  function automatic ghtc_pkg::ghtc_cfg_type put_field(input ghtc_pkg::ghtc_cfg_type c,
      input logic [2:0] m, input logic [3:0] s, input logic [3:0] v);
    put_field = c;
    unique case ({m, s})
      7'h21: put_field.main_mode = v[0];
      7'h22: put_field.log_level = v[2:0];
      7'h31: put_field.baud = v[2:0];
      7'h32: put_field.pwr_msg = v[0];
      7'h33: put_field.rot = v[1:0];
      7'h34: put_field.rate = v[2:0];
      7'h35: put_field.sentence = v[1:0];
      7'h36: put_field.talker = v[0];
      7'h37: put_field.checksum = v[0];
      7'h41: put_field.in_range = v[0];
      7'h42: put_field.sync_gear = v[2:0];
      7'h43: put_field.ref_freq = v[1:0];
      7'h51: put_field.step_gear = v[2:0];
      default: put_field = c;
    endcase
  endfunction

  ghtc_pkg::ghtc_cfg_type next_cfg;
  ghtc_pkg::ghtc_menu_type state;
  logic [2:0] prev_sector;
  logic prev_valid;
  logic [2:0] eff_phase;
  logic [3:0] cur;
  logic [2:0] diff;
  logic track_ok;
  logic fwd_step;
  logic back_step;
  logic [16:0] step_sel;
  logic abs_mode;
  logic [7:0] addr;
  logic acc_wr;
  logic key_commit;
  logic align_commit;
  logic apb_head_wr;
  logic [2:0] next_preset;

  assign addr = paddr[7:0];
  assign acc_wr = psel & penable & pready & pwrite;
  assign key_commit = (state == ghtc_pkg::MS_EDIT) & keys_i.set;
  assign align_commit = (state == ghtc_pkg::MS_ALIGN) & keys_i.set;
  assign apb_head_wr = acc_wr & (addr == ghtc_pkg::OFS_HEADING)
    & (pwdata[16:0] < ghtc_pkg::HEAD_FULL);

  // Synchro signs are taken relative to the reference; swap inverts all three
  always_comb
  begin
    eff_phase = {phase_in_one_i, phase_in_two_i, phase_in_three_i};
    if (cfg_o.main_mode == ghtc_pkg::MODE_SYNCHRO)
      eff_phase = eff_phase ^ {3{ref_in_two_i}};
  end

  // Sector decode and direction from the order of pattern changes
  assign cur = sector_of(eff_phase);
  assign track_ok = cur[3] & ((cfg_o.main_mode == ghtc_pkg::MODE_STEPPER)
    | (ref_in_one_i ^ ref_in_two_i));
  assign diff = (cur[2:0] >= prev_sector) ? cur[2:0] - prev_sector
    : 3'h6 - prev_sector + cur[2:0];
  assign fwd_step = track_ok & prev_valid & (diff == 3'h1);
  assign back_step = track_ok & prev_valid & (diff == 3'h5);
  assign step_sel = gear_step((cfg_o.main_mode == ghtc_pkg::MODE_STEPPER)
    ? cfg_o.step_gear : cfg_o.sync_gear);
  assign abs_mode = (cfg_o.main_mode == ghtc_pkg::MODE_SYNCHRO)
    & (cfg_o.sync_gear == ghtc_pkg::GEAR_1X);

  // Last seen sector; an illegal pattern keeps the old reference
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      prev_sector <= 3'h0;
      prev_valid <= 1'b0;
    end
    else if (track_ok)
    begin
      prev_sector <= cur[2:0];
      prev_valid <= 1'b1;
    end
  end

  // Tracked heading; loads from alignment or APB win over movement
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      heading_o <= ghtc_pkg::HEAD_RESET;
    else if (align_commit)
      heading_o <= align_value_o;
    else if (apb_head_wr)
      heading_o <= pwdata[16:0];
    else if (abs_mode && track_ok)
      heading_o <= 17'(cur[2:0] * ghtc_pkg::SECTOR_SPAN);
    else if (fwd_step)
      heading_o <= wrap_add(heading_o, step_sel);
    else if (back_step)
      heading_o <= wrap_sub(heading_o, step_sel);
  end

  // Configuration: preset, then APB word, then key commit; result sanitised
  always_comb
  begin
    next_cfg = cfg_o;
    next_preset = preset_o;
    if (acc_wr && addr == ghtc_pkg::OFS_PRESET)
    begin
      next_preset = pwdata[2:0];
      next_cfg = apply_preset(cfg_o, pwdata[2:0]);
    end
    else if (acc_wr && addr == ghtc_pkg::OFS_CONFIG)
      next_cfg = pwdata[25:0];
    else if (key_commit && menu_main_o == 3'h6)
    begin
      next_preset = edit_value_o[2:0];
      next_cfg = apply_preset(cfg_o, edit_value_o[2:0]);
    end
    else if (key_commit)
      next_cfg = put_field(cfg_o, menu_main_o, menu_sub_o, edit_value_o);
    next_cfg = sanitize(next_cfg);
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      cfg_o <= ghtc_pkg::CFG_RESET;
      preset_o <= ghtc_pkg::PRESET_OFF;
    end
    else
    begin
      cfg_o <= next_cfg;
      preset_o <= next_preset;
    end
  end

  // Key menu; set has priority over exit, exit over plus, plus over minus
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state <= ghtc_pkg::MS_NORMAL;
      menu_main_o <= 3'h1;
      menu_sub_o <= 4'h1;
      edit_value_o <= 4'h0;
      align_value_o <= ghtc_pkg::HEAD_RESET;
    end
    else
    begin
      unique case (state)
        ghtc_pkg::MS_NORMAL:
          if (keys_i.set)
          begin
            state <= ghtc_pkg::MS_TOP;
            menu_main_o <= 3'h0;
          end
        ghtc_pkg::MS_TOP:
          // Item 0 is alignment, item 1 is set-up
          if (keys_i.set && menu_main_o == 3'h0)
          begin
            state <= ghtc_pkg::MS_ALIGN;
            align_value_o <= heading_o;
          end
          else if (keys_i.set)
          begin
            state <= ghtc_pkg::MS_MAIN;
            menu_main_o <= 3'h1;
          end
          else if (keys_i.exit)
            state <= ghtc_pkg::MS_NORMAL;
          else if (keys_i.plus || keys_i.minus)
            menu_main_o <= {2'h0, ~menu_main_o[0]};
        ghtc_pkg::MS_ALIGN:
          if (keys_i.set || keys_i.exit)
            state <= ghtc_pkg::MS_NORMAL;
          else if (keys_i.plus)
            align_value_o <= wrap_add(align_value_o, ghtc_pkg::ALIGN_STEP);
          else if (keys_i.minus)
            align_value_o <= wrap_sub(align_value_o, ghtc_pkg::ALIGN_STEP);
        ghtc_pkg::MS_MAIN:
          if (keys_i.set)
          begin
            state <= ghtc_pkg::MS_SUB;
            menu_sub_o <= 4'h1;
          end
          else if (keys_i.exit)
            state <= ghtc_pkg::MS_NORMAL;
          else if (keys_i.plus)
            menu_main_o <= (menu_main_o == 3'h6) ? 3'h1 : menu_main_o + 3'h1;
          else if (keys_i.minus)
            menu_main_o <= (menu_main_o == 3'h1) ? 3'h6 : menu_main_o - 3'h1;
        ghtc_pkg::MS_SUB:
          // Product data cannot be opened for editing
          if (keys_i.set && menu_main_o != 3'h1)
          begin
            state <= ghtc_pkg::MS_EDIT;
            edit_value_o <= get_field(cfg_o, preset_o, menu_main_o, menu_sub_o);
          end
          else if (keys_i.set)
            state <= ghtc_pkg::MS_SUB;
          else if (keys_i.exit)
            state <= ghtc_pkg::MS_MAIN;
          else if (keys_i.plus)
            menu_sub_o <= (menu_sub_o == sub_count(menu_main_o)) ? 4'h1
              : menu_sub_o + 4'h1;
          else if (keys_i.minus)
            menu_sub_o <= (menu_sub_o == 4'h1) ? sub_count(menu_main_o)
              : menu_sub_o - 4'h1;
        ghtc_pkg::MS_EDIT:
          if (keys_i.set || keys_i.exit)
            state <= ghtc_pkg::MS_SUB;
          else if (keys_i.plus)
            edit_value_o <= (edit_value_o >= val_count(menu_main_o, menu_sub_o) - 4'h1)
              ? 4'h0 : edit_value_o + 4'h1;
          else if (keys_i.minus)
            edit_value_o <= (edit_value_o == 4'h0)
              ? val_count(menu_main_o, menu_sub_o) - 4'h1 : edit_value_o - 4'h1;
        default:
          state <= ghtc_pkg::MS_NORMAL;
      endcase
    end
  end

  assign menu_state_o = state;

  // Store request pulses once when set-up is left for normal operation
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      nv_store_o <= 1'b0;
    else
      nv_store_o <= (state == ghtc_pkg::MS_MAIN) & ~keys_i.set & keys_i.exit;
  end

  // APB slave: no wait states; pready, prdata and pslverr come from flops loaded at the end of the setup cycle
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel & ~penable & ~pready;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (psel && !penable)
      begin
        unique case (addr)
          ghtc_pkg::OFS_CONFIG: prdata <= {6'h00, cfg_o};
          ghtc_pkg::OFS_PRESET: prdata <= {29'h0, preset_o};
          ghtc_pkg::OFS_HEADING: prdata <= {15'h0000, heading_o};
          ghtc_pkg::OFS_STATUS: prdata <= {24'h00_0000, prev_valid, prev_sector,
            1'b0, state};
          ghtc_pkg::OFS_PROD_ID: prdata <= PROD_ID;
          ghtc_pkg::OFS_SERIAL: prdata <= SERIAL;
          ghtc_pkg::OFS_VERSION: prdata <= VERSION;
          default: pslverr <= 1'b1;
        endcase
        // Writes to read-only product data and status are refused
        if (pwrite && addr >= ghtc_pkg::OFS_STATUS)
          pslverr <= 1'b1;
      end
    end
  end

  a_heading_range: assert property (@(posedge clk_i) disable iff (!resetn_i)
    heading_o < ghtc_pkg::HEAD_FULL) else $error("Heading out of range");
  a_fwd_step: assert property (@(posedge clk_i) disable iff (!resetn_i)
    fwd_step && !align_commit && !apb_head_wr && !abs_mode
    |=> heading_o == wrap_add($past(heading_o), $past(step_sel)))
    else $error("Forward step wrong");
  a_back_step: assert property (@(posedge clk_i) disable iff (!resetn_i)
    back_step && !align_commit && !apb_head_wr && !abs_mode
    |=> heading_o == wrap_sub($past(heading_o), $past(step_sel)))
    else $error("Backward step wrong");
  a_skip_hold: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !fwd_step && !back_step && !align_commit && !apb_head_wr && !abs_mode
    |=> $stable(heading_o)) else $error("Heading moved without a step");
  a_rate_baud: assert property (@(posedge clk_i) disable iff (!resetn_i)
    cfg_o.baud <= ghtc_pkg::BAUD_4800 |-> cfg_o.rate < ghtc_pkg::RATE_30HZ)
    else $error("Fast rate at low baud");
  a_step_gear: assert property (@(posedge clk_i) disable iff (!resetn_i)
    cfg_o.step_gear <= ghtc_pkg::GEAR_36) else $error("Stepper gear 1x");
  a_align_commit: assert property (@(posedge clk_i) disable iff (!resetn_i)
    align_commit |=> heading_o == $past(align_value_o) && state == ghtc_pkg::MS_NORMAL)
    else $error("Alignment not committed");
  a_nv_store: assert property (@(posedge clk_i) disable iff (!resetn_i)
    state == ghtc_pkg::MS_MAIN && keys_i.exit && !keys_i.set
    |=> nv_store_o ##1 !nv_store_o) else $error("Store pulse missing");
  a_preset_default: assert property (@(posedge clk_i) disable iff (!resetn_i)
    acc_wr && addr == ghtc_pkg::OFS_PRESET && pwdata[2:0] == ghtc_pkg::PRESET_DEFAULT
    |=> cfg_o.main_mode == ghtc_pkg::MODE_STEPPER && cfg_o.step_gear == 3'h1
    && cfg_o.baud == ghtc_pkg::BAUD_4800) else $error("Default preset not applied");
  a_apb_ready: assert property (@(posedge clk_i) disable iff (!resetn_i)
    psel && !penable |=> pready ##1 !pready) else $error("APB ready timing");

  c_fwd: cover property (@(posedge clk_i) disable iff (!resetn_i) fwd_step);
  c_back: cover property (@(posedge clk_i) disable iff (!resetn_i) back_step);
  c_store: cover property (@(posedge clk_i) disable iff (!resetn_i) nv_store_o);
  c_align: cover property (@(posedge clk_i) disable iff (!resetn_i) align_commit);

endmodule

// [tb/ghtc_gyro_model.sv]
// Gyro stepper transmitter model driving the three on/off phase lines
module ghtc_gyro_model (
  input wire logic clk_i,
  input wire logic [2:0] sector_i,
  input wire logic bad_i,
  output logic phase_one_o,
  output logic phase_two_o,
  output logic phase_three_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Sector patterns {one,two,three}, one per 60 degrees of transmitter turn
  localparam logic [2:0] PATS [6] = '{3'h4, 3'h6, 3'h2, 3'h3, 3'h1, 3'h5};
  // Lines change just after the edge; all-on stands for a broken pattern
  always @(posedge clk_i)
  begin
    if (bad_i)
      {phase_one_o, phase_two_o, phase_three_o} <= 3'h7;
    else
      {phase_one_o, phase_two_o, phase_three_o} <= PATS[sector_i];
  end
endmodule

// [tb/tb_top.sv]
// Self-checking bench for the heading tracker: APB, phases and keys
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, p1, p2, p3, bad = 1'b0, ref_one = 1'b0, ref_two = 1'b1, nv;
  logic [2:0] sec = 3'h0;
  ghtc_pkg::ghtc_keys_type keys_i = 4'h0;
  ghtc_pkg::ghtc_cfg_type cfg_o, c;
  ghtc_pkg::ghtc_menu_type menu_state_o;
  logic [16:0] heading_o, h;
  int n_mismatch = 0, cmp_count = 0, cyc = 0;
  logic nv_store_w;
  logic [2:0] preset_w;
  always #50 clk_i = ~clk_i;
  ghtc_gyro_model gyro_u (.clk_i(clk_i), .sector_i(sec), .bad_i(bad), .phase_one_o(p1),
    .phase_two_o(p2), .phase_three_o(p3));
  ghtc_top dut_u (.clk_i(clk_i), .resetn_i(resetn_i), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .phase_in_one_i(p1), .phase_in_two_i(p2), .phase_in_three_i(p3),
    .ref_in_one_i(ref_one), .ref_in_two_i(ref_two), .keys_i(keys_i), .cfg_o(cfg_o),
    .preset_o(preset_w), .heading_o(heading_o), .menu_state_o(menu_state_o), .menu_main_o(),
    .menu_sub_o(), .edit_value_o(), .align_value_o(), .nv_store_o(nv_store_w));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // One APB transfer; the answer is taken at the rising edge that samples pready high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do @(posedge clk_i); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Registers written at that edge settle before callers look at them
    @(negedge clk_i);
  endtask
  task automatic key(input logic [3:0] k);
    @(posedge clk_i);
    keys_i <= k;
    @(posedge clk_i);
    keys_i <= 4'h0;
    repeat (2) @(posedge clk_i);
  endtask
  // Move the transmitter, give the tracker time, compare the heading
  task automatic step(input logic [2:0] s, input logic b, input logic [16:0] e);
    @(posedge clk_i);
    sec <= s;
    bad <= b;
    repeat (4) @(posedge clk_i);
    check("heading", {15'h0, heading_o}, {15'h0, e});
  endtask
  // Hang guard: the whole run needs well under two thousand cycles
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_mismatch++;
      complete_run();
    end
  end
  initial
  begin
    repeat (20) @(posedge clk_i);
    resetn_i <= 1'b1;
    check("cfg reset", {6'h0, cfg_o}, {6'h0, ghtc_pkg::CFG_RESET});
    step(3'h1, 1'b0, 17'h00078);
    step(3'h0, 1'b0, 17'h00000);
    step(3'h5, 1'b0, 17'h1F9C8);
    step(3'h1, 1'b0, 17'h1F9C8);
    step(3'h1, 1'b1, 17'h1F9C8);
    step(3'h0, 1'b0, 17'h1F950);
    step(3'h1, 1'b0, 17'h1F9C8);
    key(4'h8);
    check("menu top", {29'h0, menu_state_o}, {29'h0, ghtc_pkg::MS_TOP});
    key(4'h8);
    key(4'h2);
    key(4'h8);
    check("aligned", {15'h0, heading_o}, 32'h0001F9EC);
    check("menu back", {29'h0, menu_state_o}, {29'h0, ghtc_pkg::MS_NORMAL});
    apb(1'b1, ghtc_pkg::OFS_HEADING, 32'h000003E8);
    apb(1'b0, ghtc_pkg::OFS_HEADING, 32'h0);
    check("heading rd", rd, 32'h000003E8);
    apb(1'b1, ghtc_pkg::OFS_PROD_ID, 32'h0);
    check("ro err", {31'h0, err}, 32'h1);
    apb(1'b0, 8'h1C, 32'h0);
    check("unmapped err", {31'h0, err}, 32'h1);
    c = ghtc_pkg::CFG_RESET;
    c.rate = ghtc_pkg::RATE_30HZ;
    apb(1'b1, ghtc_pkg::OFS_CONFIG, {6'h0, c});
    check("rate clamp", {29'h0, cfg_o.rate}, {29'h0, ghtc_pkg::RATE_20HZ});
    c.baud = 3'h3;
    apb(1'b1, ghtc_pkg::OFS_CONFIG, {6'h0, c});
    apb(1'b0, ghtc_pkg::OFS_CONFIG, 32'h0);
    check("config rd", rd, {6'h0, c});
    for (int p = 2; p <= 5; p++)
    begin
      apb(1'b1, ghtc_pkg::OFS_PRESET, p);
      check("preset gear", {29'h0, cfg_o.sync_gear}, p < 4 ? 32'h0 : 32'h2);
      check("preset range", {31'h0, cfg_o.in_range}, p % 2);
      check("preset rate", {29'h0, cfg_o.rate}, 32'h0);
    end
    apb(1'b1, ghtc_pkg::OFS_PRESET, 32'h0);
    check("preset off", {31'h0, cfg_o.main_mode}, 32'h0);
    apb(1'b1, ghtc_pkg::OFS_PRESET, 32'h1);
    check("preset dflt", {29'h0, cfg_o.step_gear}, 32'h1);
    check("preset code", {29'h0, preset_w}, 32'h1);
    // Synchro 1x: absolute sector, reference swap moves it by half a turn
    c = ghtc_pkg::CFG_RESET;
    c.main_mode = ghtc_pkg::MODE_SYNCHRO;
    c.sync_gear = ghtc_pkg::GEAR_1X;
    apb(1'b1, ghtc_pkg::OFS_CONFIG, {6'h0, c});
    step(3'h1, 1'b0, 17'h15180);
    @(posedge clk_i);
    ref_one <= 1'b1;
    ref_two <= 1'b0;
    step(3'h1, 1'b0, 17'h05460);
    // Keys: set-up menu 2.1, step the value and commit stepper mode
    key(4'h8);
    key(4'h2);
    key(4'h8);
    key(4'h2);
    key(4'h8);
    key(4'h8);
    key(4'h2);
    key(4'h8);
    check("key mode", {31'h0, cfg_o.main_mode}, {31'h0, ghtc_pkg::MODE_STEPPER});
    key(4'h4);
    @(posedge clk_i);
    keys_i <= 4'h4;
    @(posedge clk_i);
    keys_i <= 4'h0;
    nv = 1'b0;
    repeat (4) @(negedge clk_i) nv = nv | nv_store_w;
    check("nv store", {31'h0, nv}, 32'h1);
    complete_run();
  end
endmodule
